// [hdl/adc_conversion_control.sv]
// Purpose: APB-controlled successive-approximation conversion sequencer
// Assumes: analog comparator result arrives on cmpIn from the array
// Notes: zero-wait APB slave, pready always high
//
// Notes on behaviour
// - start on completed 0-1-0 start pulse
// - busy flag set when conversion triggered
// - busy flag cleared at conversion end
// - completion sets converter interrupt flag
// - enabled flag raises interrupt request
// - clock divides system clock by 2^code
// - analog power follows enable bit
// - disabled converter powers nothing and connects no source; reference select stays live
// - four sample then twelve convert cycles
// - conversion runs without processor help
// - result valid when busy flag falls
// - twelve-bit unsigned, full scale FFF
// - one step equals reference over 4096
// - reference follows reference-select field
// - result layout follows format bit
// - channel codes route pins, top bit none
// - source codes pick bandgap, ground, pin
// - reference code 01 picks analog supply
//
// The placing of the registers and the APB interface to the registers were decided locally.
module adc_conversion_control
    import adccc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmpIn,
    output logic [11:0] dacCode,
    output logic sampleHold,
    output logic analogPowerOn,
    output logic [7:0] chanConnect,
    output logic bandgapSel,
    output logic groundSel,
    output logic refIsSupply,
    output logic irqReq
);
    typedef enum logic [1:0] {
        ADCCC_IDLE,
        ADCCC_SAMPLE,
        ADCCC_CONVERT
    } adccc_state_t;

    adccc_state_t state_q;
    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [11:0] result_q;
    logic [11:0] sar_q;
    logic [4:0] phaseCnt_q;
    logic [3:0] bitIdx_q;
    logic startSeen_q;
    logic globalEn_q;
    logic irqEn_q;
    logic irqFlag_q;
    logic cmpMeta_q;
    logic cmpSync_q;
    logic busy;
    logic tick;
    logic wrEn;
    logic rdEn;
    logic mapped;
    logic trigger;
    logic done;
    logic wrIrq;
    adccc_src_t srcKind;

    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && !pwrite;
    assign pready = 1'b1;
    assign mapped = (paddr == ADDR_CTRL0) || (paddr == ADDR_CTRL1) ||
        (paddr == ADDR_RESH) || (paddr == ADDR_RESL) ||
        (paddr == ADDR_IRQ);
    assign pslverr = psel && penable && !mapped;
    assign busy = (state_q != ADCCC_IDLE);
    assign wrIrq = wrEn && (paddr == ADDR_IRQ);

    // comparator comes from the analog domain
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmpMeta_q <= 1'b0;
            cmpSync_q <= 1'b0;
        end else if (ce) begin
            cmpMeta_q <= cmpIn;
            cmpSync_q <= cmpMeta_q;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl0_q <= CTRL0_RESET;
            ctrl1_q <= CTRL1_RESET;
        end else if (ce && wrEn) begin
            if (paddr == ADDR_CTRL0) begin
                ctrl0_q <= pwdata[7:0];
            end
            if (paddr == ADDR_CTRL1) begin
                ctrl1_q <= pwdata[7:0];
            end
        end
    end

    // trigger only on the falling half of a completed pulse
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            startSeen_q <= 1'b0;
        end else if (ce) begin
            if (!ctrl0_q[C0_EN]) begin
                startSeen_q <= 1'b0;
            end else if (ctrl0_q[C0_START]) begin
                startSeen_q <= 1'b1;
            end else if (startSeen_q) begin
                startSeen_q <= 1'b0;
            end
        end
    end
    assign trigger = startSeen_q && !ctrl0_q[C0_START] &&
        ctrl0_q[C0_EN];

    adccc_clkdiv u_div (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .run(busy),
        .divSel(ctrl1_q[C1_DIV_LSB +: 3]),
        .tick(tick)
    );

    assign done = tick && (state_q == ADCCC_CONVERT) &&
        (phaseCnt_q == CONVERT_CYCLES - 5'h01);

    // sequencer runs on its own once triggered
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ADCCC_IDLE;
            phaseCnt_q <= 5'h00;
        end else if (ce) begin
            if (!ctrl0_q[C0_EN]) begin
                state_q <= ADCCC_IDLE;
                phaseCnt_q <= 5'h00;
            end else begin
                unique case (state_q)
                    ADCCC_IDLE: begin
                        phaseCnt_q <= 5'h00;
                        if (trigger) begin
                            state_q <= ADCCC_SAMPLE;
                        end
                    end
                    ADCCC_SAMPLE: begin
                        if (tick) begin
                            if (phaseCnt_q == SAMPLE_CYCLES - 5'h01) begin
                                state_q <= ADCCC_CONVERT;
                                phaseCnt_q <= 5'h00;
                            end else begin
                                phaseCnt_q <= phaseCnt_q + 5'h01;
                            end
                        end
                    end
                    ADCCC_CONVERT: begin
                        if (tick) begin
                            if (done) begin
                                state_q <= ADCCC_IDLE;
                                phaseCnt_q <= 5'h00;
                            end else begin
                                phaseCnt_q <= phaseCnt_q + 5'h01;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // binary search, msb first; one bit per conversion clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sar_q <= 12'h000;
            bitIdx_q <= 4'hB;
        end else if (ce) begin
            if (state_q != ADCCC_CONVERT) begin
                sar_q <= 12'h800;
                bitIdx_q <= 4'hB;
            end else if (tick) begin
                if (!cmpSync_q) begin
                    sar_q[bitIdx_q] <= 1'b0;
                end
                if (bitIdx_q != 4'h0) begin
                    sar_q[bitIdx_q - 4'h1] <= 1'b1;
                    bitIdx_q <= bitIdx_q - 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result_q <= RESULT_RESET;
        end else if (ce && done) begin
            result_q <= cmpSync_q ? sar_q :
                (sar_q & ~12'h001);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            globalEn_q <= 1'b0;
            irqEn_q <= 1'b0;
            irqFlag_q <= 1'b0;
        end else if (ce) begin
            if (wrIrq) begin
                globalEn_q <= pwdata[IRQ_GLOBAL];
                irqEn_q <= pwdata[IRQ_EN];
            end
            if (done) begin
                irqFlag_q <= 1'b1;
            end else if (wrIrq) begin
                irqFlag_q <= pwdata[IRQ_FLAG];
            end
        end
    end
    assign irqReq = irqFlag_q && irqEn_q && globalEn_q;

    adccc_route u_route (
        .srcSel(ctrl1_q[C1_SRC_LSB +: 3]),
        .chanSel(ctrl0_q[C0_CH_LSB +: 4]),
        .refSel(ctrl1_q[C1_REF_LSB +: 2]),
        .powerEn(ctrl0_q[C0_EN]),
        .srcKind(srcKind),
        .chanConnect(chanConnect),
        .refIsSupply(refIsSupply)
    );
    assign bandgapSel = ctrl0_q[C0_EN] && (srcKind == ADCCC_SRC_BANDGAP);
    assign groundSel = ctrl0_q[C0_EN] && (srcKind == ADCCC_SRC_GND);
    assign analogPowerOn = ctrl0_q[C0_EN];
    assign sampleHold = (state_q == ADCCC_SAMPLE);
    assign dacCode = sar_q;

    // format 0 left-justifies, format 1 right-justifies
    always_comb begin
        prdata = 32'h0000_0000;
        if (rdEn) begin
            unique case (paddr)
                ADDR_CTRL0: prdata = {24'h000000, ctrl0_q[7],
                    busy, ctrl0_q[5:0]};
                ADDR_CTRL1: prdata = {24'h000000, ctrl1_q};
                ADDR_RESH: prdata = ctrl0_q[C0_FMT] ?
                    {28'h0000000, result_q[11:8]} :
                    {24'h000000, result_q[11:4]};
                ADDR_RESL: prdata = ctrl0_q[C0_FMT] ?
                    {24'h000000, result_q[7:0]} :
                    {24'h000000, result_q[3:0], 4'h0};
                ADDR_IRQ: prdata = {29'h00000000, irqFlag_q, irqEn_q,
                    globalEn_q};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    sequence trig_s;
        trigger && state_q == ADCCC_IDLE && ce;
    endsequence

    start_pulse_a: assert property (@(posedge clk) disable iff (reset)
        (state_q == ADCCC_IDLE ##1 state_q == ADCCC_SAMPLE)
        |-> $past(trigger))
        else $error("conversion began without completed start pulse");
    busy_set_a: assert property (@(posedge clk) disable iff (reset)
        trig_s |=> busy)
        else $error("busy flag not set after trigger");
    busy_clear_a: assert property (@(posedge clk) disable iff (reset)
        done && ce && ctrl0_q[C0_EN] |=> !busy)
        else $error("busy flag not cleared at end");
    flag_set_a: assert property (@(posedge clk) disable iff (reset)
        done && ce |=> irqFlag_q)
        else $error("interrupt flag not set at end");
    irq_gate_a: assert property (@(posedge clk) disable iff (reset)
        done && ce && irqEn_q && globalEn_q && !wrIrq |=> irqReq)
        else $error("interrupt not raised after enabled completion");
    sample_len_a: assert property (@(posedge clk) disable iff (reset)
        $rose(state_q == ADCCC_CONVERT) |->
        $past(phaseCnt_q) == SAMPLE_CYCLES - 5'h01)
        else $error("sample phase length wrong");
    power_off_a: assert property (@(posedge clk) disable iff (reset)
        !analogPowerOn |-> chanConnect == 8'h00 && !bandgapSel
        && !groundSel)
        else $error("analog path active while disabled");
    result_hold_a: assert property (@(posedge clk) disable iff (reset)
        busy && !done |=> $stable(result_q))
        else $error("result changed during conversion");
    div_one_a: assert property (@(posedge clk) disable iff (reset)
        busy && ce && ctrl1_q[2:0] == 3'h0 && $past(busy) |-> tick)
        else $error("divide by one missing ticks");
endmodule : adc_conversion_control

// [hdl/adccc_pkg.sv]
// Purpose: shared constants for the conversion control block
// Assumes: APB, 32-bit words, 125 MHz system clock
// Notes: one aligned word per register
package adccc_pkg;
    localparam logic [11:0] ADDR_CTRL0 = 12'h000;
    localparam logic [11:0] ADDR_CTRL1 = 12'h004;
    localparam logic [11:0] ADDR_RESH = 12'h008;
    localparam logic [11:0] ADDR_RESL = 12'h00C;
    localparam logic [11:0] ADDR_IRQ = 12'h010;
    localparam logic [11:0] ADDR_SAMPLE = 12'h014;
    // control register 0 fields
    localparam int C0_START = 7;
    localparam int C0_BUSY = 6;
    localparam int C0_EN = 5;
    localparam int C0_FMT = 4;
    localparam int C0_CH_LSB = 0;
    // control register 1 fields
    localparam int C1_SRC_LSB = 5;
    localparam int C1_REF_LSB = 3;
    localparam int C1_DIV_LSB = 0;
    // interrupt control fields
    localparam int IRQ_GLOBAL = 0;
    localparam int IRQ_EN = 1;
    localparam int IRQ_FLAG = 2;
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    // sequence lengths in conversion-clock cycles
    localparam logic [4:0] SAMPLE_CYCLES = 5'h04;
    localparam logic [4:0] CONVERT_CYCLES = 5'h0C;
    localparam logic [11:0] FULL_SCALE = 12'hFFF;
    // input source selections
    typedef enum logic [1:0] {
        ADCCC_SRC_EXT,
        ADCCC_SRC_BANDGAP,
        ADCCC_SRC_GND
    } adccc_src_t;
endpackage : adccc_pkg

// [hdl/adccc_clkdiv.sv]
// Purpose: conversion clock enable divided from the system clock
// Assumes: divider code 0..7 selects divide by 1..128
// Notes: counter restarts when run is low so each conversion is aligned
module adccc_clkdiv
    import adccc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic run,
    input wire logic [2:0] divSel,
    output logic tick
);
    logic [6:0] cnt_q;
    logic [6:0] limit;
    assign limit = 7'((8'h01 << divSel) - 8'h01);
    assign tick = run && (cnt_q == limit);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 7'h00;
        end else if (ce) begin
            if (!run || tick) begin
                cnt_q <= 7'h00;
            end else begin
                cnt_q <= cnt_q + 7'h01;
            end
        end
    end
endmodule : adccc_clkdiv

// [hdl/adccc_route.sv]
// Purpose: analog input and reference routing decode
// Assumes: codes as programmed in control registers
// Notes: purely combinational
module adccc_route
    import adccc_pkg::*;
(
    input wire logic [2:0] srcSel,
    input wire logic [3:0] chanSel,
    input wire logic [1:0] refSel,
    input wire logic powerEn,
    output adccc_pkg::adccc_src_t srcKind,
    output logic [7:0] chanConnect,
    output logic refIsSupply
);
    always_comb begin
        unique case (srcSel)
            3'h1: srcKind = ADCCC_SRC_BANDGAP;
            3'h2, 3'h3, 3'h4: srcKind = ADCCC_SRC_GND;
            default: srcKind = ADCCC_SRC_EXT;
        endcase
    end
    // a pin is only switched in while powered and in range
    assign chanConnect = (powerEn && !chanSel[3]) ?
        8'(8'h01 << chanSel[2:0]) : 8'h00;
    assign refIsSupply = (refSel == 2'h1);
endmodule : adccc_route

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the conversion control block
// Assumes: zero-wait APB slave, comparator held per conversion clock
// Notes: an ideal comparator model steers the trial code to the target
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
    import adccc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0, tgt = 0;
    logic [31:0] pwdata = 0, prdata, rdv, prevH = 0;
    logic pready, pslverr, cmpIn = 0, errv, sampleHold, analogPowerOn;
    logic [11:0] dacCode;
    logic [7:0] chanConnect;
    logic bandgapSel, groundSel, refIsSupply, irqReq;
    int errors = 0, nTests = 0, shCnt = 0;
    int expQ[$];
    // settling wait after enabling; the length is a plain choice of ours
    localparam int SETTLE_CYCLES = 8;
    adc_conversion_control u_dut (.clk(clk), .reset(reset), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmpIn(cmpIn), .dacCode(dacCode),
        .sampleHold(sampleHold), .analogPowerOn(analogPowerOn),
        .chanConnect(chanConnect), .bandgapSel(bandgapSel),
        .groundSel(groundSel), .refIsSupply(refIsSupply), .irqReq(irqReq));
    initial begin
        forever #4 clk = ~clk;
    end
    // comparator says input >= trial; registered so it changes off the edge
    always @(posedge clk) begin
        cmpIn <= (dacCode <= tgt);
        if (sampleHold === 1'b1) shCnt <= shCnt + 1;
    end
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        if (k >= 100) begin
            errors++;
            $display("wrong value at %0t: pready timeout", $time);
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input int d);
        apb(1'b1, a, 32'(d));
    endtask : wr
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic conv(input int t, input int dv, input int fm, input int ie);
        int c0, k, e, sh0;
        c0 = 32'h20 | (fm << 4);
        expQ.push_back(t);
        wr(ADDR_CTRL1, dv);
        wr(ADDR_CTRL0, c0);
        wr(ADDR_IRQ, ie ? 3 : 0);
        repeat (SETTLE_CYCLES) @(posedge clk);
        tgt <= 12'(t);
        sh0 = shCnt;
        wr(ADDR_CTRL0, c0 | 32'h80);
        wr(ADDR_CTRL0, c0);
        rd(ADDR_CTRL0);
        `CHK(rdv[C0_BUSY], 1'b1)
        rd(ADDR_RESH);
        `CHK(rdv, fm ? (prevH >> 8) : (prevH >> 4))
        k = 0;
        do begin
            rd(ADDR_CTRL0);
            k++;
        end while (rdv[C0_BUSY] !== 1'b0 && k < 500);
        `CHK(rdv[C0_BUSY], 1'b0)
        `CHK(shCnt - sh0, 4 * (1 << dv))
        e = expQ.pop_front();
        prevH = 32'(e);
        rd(ADDR_RESH);
        `CHK(rdv, fm ? (prevH >> 8) : (prevH >> 4))
        rd(ADDR_RESL);
        `CHK(rdv, fm ? 32'(e & 255) : 32'((e & 15) << 4))
        rd(ADDR_IRQ);
        `CHK(rdv[IRQ_FLAG], 1'b1)
        `CHK(irqReq, 1'(ie))
        wr(ADDR_IRQ, ie ? 3 : 0);
        `CHK(irqReq, 1'b0)
        $display("test conversion %h done", e);
    endtask : conv
    initial begin
        #(8 * 60000);
        errors++;
        close_out();
    end
    initial begin
        bit ext;
        void'($urandom(1));
        repeat (3) @(posedge clk);
        reset <= 0;
        rd(ADDR_CTRL0);
        `CHK(rdv, 32'(CTRL0_RESET))
        rd(ADDR_CTRL1);
        `CHK(rdv, 32'(CTRL1_RESET))
        rd(12'h0FC);
        `CHK(errv, 1'b1)
        `CHK(rdv, 32'h0)
        $display("test reset done");
        // internal sources only with the channel parked on a missing pin
        for (int s = 0; s < 8; s++) begin
            for (int c = 0; c < 16; c++) begin
                for (int r = 0; r < 4; r++) begin
                    ext = (s == 0 || s >= 5);
                    if (!ext && c < 8) continue;
                    wr(ADDR_CTRL1, (s << 5) | (r << 3) | 2);
                    wr(ADDR_CTRL0, 32'h20 | c);
                    `CHK(chanConnect, (ext && c < 8) ? 8'(1 << c) : 8'h0)
                    `CHK(bandgapSel, 1'(s == 1))
                    `CHK(groundSel, 1'(s >= 2 && s <= 4))
                    `CHK(refIsSupply, 1'(r == 1))
                end
            end
        end
        wr(ADDR_CTRL1, 32'h20);
        wr(ADDR_CTRL0, 32'h08);
        `CHK(analogPowerOn, 1'b0)
        `CHK(bandgapSel, 1'b0)
        `CHK(chanConnect, 8'h0)
        ce <= 0;
        wr(ADDR_CTRL1, 32'h55);
        ce <= 1;
        rd(ADDR_CTRL1);
        `CHK(rdv, 32'h20)
        wr(ADDR_CTRL1, 32'h00);
        wr(ADDR_CTRL0, 32'h03);
        `CHK(chanConnect, 8'h0)
        $display("test routing done");
        conv(12'hFFF, 2, 0, 1);
        conv(0, 3, 1, 0);
        // extreme codes settle even with the short conversion clocks
        conv(12'hFFF, 0, 1, 0);
        conv(0, 1, 0, 1);
        conv($urandom % 4096, 6, 0, 0);
        for (int i = 0; i < 4; i++) begin
            conv($urandom % 4096, 2 + i % 3, i % 2, i % 2);
        end
        // a start bit left high must not trigger; clearing enable aborts
        wr(ADDR_CTRL1, 2);
        wr(ADDR_CTRL0, 32'hA0);
        repeat (20) @(posedge clk);
        rd(ADDR_CTRL0);
        `CHK(rdv[C0_BUSY], 1'b0)
        wr(ADDR_CTRL0, 32'h20);
        rd(ADDR_CTRL0);
        `CHK(rdv[C0_BUSY], 1'b1)
        `CHK(analogPowerOn, 1'b1)
        wr(ADDR_CTRL0, 32'h00);
        `CHK(analogPowerOn, 1'b0)
        repeat (80) @(posedge clk);
        rd(ADDR_IRQ);
        `CHK(rdv[IRQ_FLAG], 1'b0)
        $display("test abort done");
        close_out();
    end
endmodule : tb_top
